// *** logic/tlc_pkg.sv ***
// Package for the traverse, length and count unit.
// Holds register offsets, reset values, terminal function codes and timing constants.
// Assumes a 32-bit classic Wishbone register bus and a 250 MHz core clock.
package tlc_pkg;

    // Core clock period in nanoseconds.
    localparam int CLK_PERIOD_NS = 4;
    // Wobble timing grain: one tick is 100 us, so period (0.1 s) times
    // coefficient (0.1 %) lands directly in ticks.
    localparam int WOBBLE_TICK_NS = 100000;
    // Core cycles per wobble tick, a longest time so it rounds down.
    localparam int WOBBLE_TICK_CYCLES = WOBBLE_TICK_NS / CLK_PERIOD_NS;
    // Full scale of the rise-time coefficient, in 0.1 % steps.
    localparam logic [9:0] COEFF_FULL = 10'h3E8;
    // Smallest legal coefficient, 0.1 %.
    localparam logic [9:0] COEFF_MIN = 10'h001;
    // Tenths added to the length accumulator per pulse.
    localparam logic [19:0] PULSE_TENTHS = 20'h0000A;

    // Number of multi-function input terminals; the last one is the fast one.
    localparam int NUM_TERM = 6;

    // Terminal function codes.
    localparam logic [7:0] FUNC_COUNT_IN = 8'h19;  // Counter input, code 25.
    localparam logic [7:0] FUNC_LENGTH_IN = 8'h1B; // Length count input, code 27.
    localparam logic [7:0] FUNC_LENGTH_CLR = 8'h1C; // Length reset, code 28.

    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_WOBBLE_PERIOD = 8'h04;
    localparam logic [7:0] OFS_RISE_TIME_COEFF = 8'h08;
    localparam logic [7:0] OFS_SWING_AMPLITUDE = 8'h0C;
    localparam logic [7:0] OFS_TARGET_LENGTH = 8'h10;
    localparam logic [7:0] OFS_MEASURED_LENGTH = 8'h14;
    localparam logic [7:0] OFS_PULSES_PER_METRE = 8'h18;
    localparam logic [7:0] OFS_FINAL_COUNT = 8'h1C;
    localparam logic [7:0] OFS_INTERMEDIATE_COUNT = 8'h20;
    localparam logic [7:0] OFS_COUNT = 8'h24;
    localparam logic [7:0] OFS_TERM_FUNC_LO = 8'h28;
    localparam logic [7:0] OFS_TERM_FUNC_HI = 8'h2C;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h30;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h34;
    localparam logic [7:0] OFS_FLAGS = 8'h38;

    // Control bit positions; both are write-only strobes.
    localparam int CTRL_COUNT_CLR_BIT = 0;
    localparam int CTRL_LENGTH_CLR_BIT = 1;

    // Interrupt status bit positions.
    localparam int IRQ_LENGTH_BIT = 0;
    localparam int IRQ_FINAL_BIT = 1;
    localparam int IRQ_INTER_BIT = 2;

    // Reset values.
    localparam logic [15:0] RST_WOBBLE_PERIOD = 16'h0064;    // 10.0 s.
    localparam logic [9:0] RST_RISE_TIME_COEFF = 10'h1F4;    // 50.0 %.
    localparam logic [9:0] RST_SWING_AMPLITUDE = 10'h000;    // 0.0 %.
    localparam logic [15:0] RST_TARGET_LENGTH = 16'h03E8;    // 1000 m.
    localparam logic [15:0] RST_PULSES_PER_METRE = 16'h03E8; // 100.0.
    localparam logic [15:0] RST_FINAL_COUNT = 16'h03E8;      // 1000.
    localparam logic [15:0] RST_INTERMEDIATE_COUNT = 16'h03E8; // 1000.

    // Wobble phase states, one-hot.
    typedef enum logic [2:0] {
        WOB_IDLE = 3'b001,
        WOB_RISE = 3'b010,
        WOB_FALL = 3'b100
    } tlc_wob_t;

endpackage

// *** logic/tlc_pin_sync.sv ***
// Input terminal conditioner for the traverse, length and count unit.
// Assumes the pin is asynchronous to clk_i; gives a clean level and a rise pulse.
`timescale 1ns/1ns
`default_nettype none

module tlc_pin_sync (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pin_i,
    output logic level_o,
    output logic rise_o
);

    // Three-stage shift; stage one feeds only stage two.
    logic [2:0] shift_q;
    // Accepted level, updated only when stages two and three agree.
    logic level_q;
    // One-cycle pulse when the accepted level goes high.
    logic rise_q;

    // A change counts only once two late stages agree, which also
    // filters single-cycle glitches on a noisy terminal.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shift_q <= 3'h0;
            level_q <= 1'b0;
            rise_q <= 1'b0;
        end else begin
            shift_q <= {shift_q[1:0], pin_i};
            if (shift_q[1] == shift_q[2]) begin
                level_q <= shift_q[2];
                rise_q <= shift_q[2] & ~level_q;
            end else begin
                rise_q <= 1'b0;
            end
        end
    end

    assign level_o = level_q;
    assign rise_o = rise_q;

endmodule

`default_nettype wire

// *** logic/tlc_top.sv ***
// Traverse, length and count unit: wobble triangle timing, metre length
// and pulse counting, with a classic Wishbone register slave.
// Assumes asynchronous terminal inputs and a single 250 MHz clock.
//
// The implementer's own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none

module tlc_top
    import tlc_pkg::*;
#(
    parameter int TICK_CYCLES = WOBBLE_TICK_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic [NUM_TERM-1:0] term_i,
    output logic length_reached_o,
    output logic final_count_o,
    output logic intermediate_count_o,
    output logic swing_active_o,
    output logic wobble_rising_o,
    output logic irq_o
);

    // Whole state of the block, except the terminal conditioners, in one record.
    typedef struct packed {
        logic ack;
        logic [31:0] rdat;
        logic irq;
        logic [15:0] wobble_period;
        logic [9:0] rise_time_coeff;
        logic [9:0] swing_amplitude;
        logic [15:0] target_length;
        logic [15:0] measured_length;
        logic [15:0] pulses_per_metre;
        logic [19:0] tenths;
        logic [15:0] final_count;
        logic [15:0] intermediate_count;
        logic [15:0] count;
        logic [31:0] func_lo;
        logic [15:0] func_hi;
        logic [2:0] status;
        logic [2:0] mask;
        logic len_hit;
        logic fin_hit;
        logic int_hit;
        tlc_wob_t wob;
        logic [31:0] tick_cnt;
        logic [25:0] phase_cnt;
    } tlc_state_t;

    tlc_state_t st_q;
    tlc_state_t st_d;

    // Conditioned terminal levels and rise pulses.
    logic [NUM_TERM-1:0] term_level;
    logic [NUM_TERM-1:0] term_rise;
    // Per-terminal function codes, flattened from the two registers.
    logic [8*NUM_TERM-1:0] func_flat;

    assign func_flat = {st_q.func_hi, st_q.func_lo};

    // One conditioner per terminal; pins are asynchronous to clk_i.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_TERM; gi++) begin : g_term
            tlc_pin_sync u_sync (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .pin_i(term_i[gi]),
                .level_o(term_level[gi]),
                .rise_o(term_rise[gi])
            );
        end
    endgenerate

    // Byte-lane merge of a write into a register's old value.
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] sel);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return res;
    endfunction

    // Terminal event decode by configured function code.
    logic len_pulse;
    logic cnt_pulse;
    logic len_clear_pin;
    always_comb begin
        len_pulse = 1'b0;
        cnt_pulse = 1'b0;
        len_clear_pin = 1'b0;
        for (int t = 0; t < NUM_TERM; t++) begin
            // Length pulses are taken only from a code 27 terminal.
            if (func_flat[8*t +: 8] == FUNC_LENGTH_IN && term_rise[t]) begin
                len_pulse = 1'b1;
            end
            // Counting listens only to code 25 terminals.
            if (func_flat[8*t +: 8] == FUNC_COUNT_IN && term_rise[t]) begin
                cnt_pulse = 1'b1;
            end
            // A code 28 terminal held active keeps the length cleared.
            if (func_flat[8*t +: 8] == FUNC_LENGTH_CLR && term_level[t]) begin
                len_clear_pin = 1'b1;
            end
        end
    end

    // Wobble phase lengths in 100 us ticks.
    logic [25:0] full_ticks;
    logic [25:0] rise_ticks;
    logic [25:0] fall_ticks;
    // Rise share of the period.
    assign rise_ticks = 26'(st_q.wobble_period * st_q.rise_time_coeff);
    assign full_ticks = 26'(st_q.wobble_period * COEFF_FULL);
    // Fall is the remainder, so rise plus fall is one period.
    assign fall_ticks = full_ticks - rise_ticks;

    // Bus decode helpers.
    logic bus_req;
    logic bus_wr;
    logic [31:0] wval;
    assign bus_req = cyc_i & stb_i & ~st_q.ack;
    assign bus_wr = bus_req & we_i;

    // Next-state logic for bus, length, count, wobble and interrupt state.
    always_comb begin
        logic [31:0] rd;
        logic [2:0] events;
        logic cnt_clr;
        logic len_clr;
        logic tick;
        logic [9:0] coeff_w;
        rd = 32'h0000_0000;
        events = 3'h0;
        cnt_clr = 1'b0;
        len_clr = 1'b0;
        tick = 1'b0;
        coeff_w = 10'h000;
        st_d = st_q;
        wval = 32'h0000_0000;

        // Wishbone answers one cycle after the request, for one cycle.
        st_d.ack = bus_req;

        // Register writes; unmapped and read-only words ignore writes.
        if (bus_wr) begin
            case (adr_i & 8'hFC)
                OFS_CTRL: begin
                    wval = lane_merge(32'h0000_0000, dat_i, sel_i);
                    cnt_clr = wval[CTRL_COUNT_CLR_BIT];
                    len_clr = wval[CTRL_LENGTH_CLR_BIT];
                end
                OFS_WOBBLE_PERIOD: begin
                    wval = lane_merge({16'h0000, st_q.wobble_period}, dat_i, sel_i);
                    st_d.wobble_period = wval[15:0];
                end
                OFS_RISE_TIME_COEFF: begin
                    wval = lane_merge({22'h000000, st_q.rise_time_coeff}, dat_i, sel_i);
                    coeff_w = wval[9:0];
                    // The coefficient is held to 0.1 % .. 100.0 %, so the
                    // fall share can never go negative.
                    if (wval[15:0] > {6'h00, COEFF_FULL}) begin
                        coeff_w = COEFF_FULL;
                    end else if (coeff_w < COEFF_MIN) begin
                        coeff_w = COEFF_MIN;
                    end
                    st_d.rise_time_coeff = coeff_w;
                end
                OFS_SWING_AMPLITUDE: begin
                    wval = lane_merge({22'h000000, st_q.swing_amplitude}, dat_i, sel_i);
                    st_d.swing_amplitude = wval[9:0];
                end
                OFS_TARGET_LENGTH: begin
                    wval = lane_merge({16'h0000, st_q.target_length}, dat_i, sel_i);
                    st_d.target_length = wval[15:0];
                end
                OFS_PULSES_PER_METRE: begin
                    wval = lane_merge({16'h0000, st_q.pulses_per_metre}, dat_i, sel_i);
                    // Zero would have the divider add a metre every cycle, so it is taken as 0.1.
                    st_d.pulses_per_metre = (wval[15:0] == 16'h0000) ? 16'h0001 : wval[15:0];
                end
                OFS_FINAL_COUNT: begin
                    wval = lane_merge({16'h0000, st_q.final_count}, dat_i, sel_i);
                    st_d.final_count = (wval[15:0] == 16'h0000) ? 16'h0001 : wval[15:0];
                end
                OFS_INTERMEDIATE_COUNT: begin
                    // Values above the final count are stored as written;
                    // the flag then never rises.
                    wval = lane_merge({16'h0000, st_q.intermediate_count}, dat_i, sel_i);
                    st_d.intermediate_count =
                        (wval[15:0] == 16'h0000) ? 16'h0001 : wval[15:0];
                end
                OFS_TERM_FUNC_LO: begin
                    st_d.func_lo = lane_merge(st_q.func_lo, dat_i, sel_i);
                end
                OFS_TERM_FUNC_HI: begin
                    wval = lane_merge({16'h0000, st_q.func_hi}, dat_i, sel_i);
                    st_d.func_hi = wval[15:0];
                end
                OFS_IRQ_MASK: begin
                    wval = lane_merge({29'h00000000, st_q.mask}, dat_i, sel_i);
                    st_d.mask = wval[2:0];
                end
                default: begin
                    st_d.ack = bus_req;
                end
            endcase
        end

        // Length accumulation: each pulse adds ten tenths and every whole
        // pulses-per-metre step peels off one metre. The divider peels one
        // metre per cycle, so bursts of very short metres settle a few
        // cycles late but are never lost.
        if (len_clr || len_clear_pin) begin
            st_d.tenths = 20'h00000;
            st_d.measured_length = 16'h0000;
        end else begin
            st_d.tenths = st_q.tenths + (len_pulse ? PULSE_TENTHS : 20'h00000);
            if (st_q.tenths >= {4'h0, st_q.pulses_per_metre}) begin
                st_d.tenths = st_d.tenths - {4'h0, st_q.pulses_per_metre};
                if (st_q.measured_length != 16'hFFFF) begin
                    st_d.measured_length = st_q.measured_length + 16'h0001;
                end
            end
        end
        // Reached only when strictly beyond the target.
        st_d.len_hit = st_q.measured_length > st_q.target_length;

        // Counter: advances on each counter pulse until the final count.
        if (cnt_clr) begin
            st_d.count = 16'h0000;
        end else if (cnt_pulse && st_q.count < st_q.final_count) begin
            st_d.count = st_q.count + 16'h0001;
        end
        st_d.fin_hit = st_q.count == st_q.final_count;
        // Stays on past the intermediate value while counting goes on.
        st_d.int_hit = (st_q.count >= st_q.intermediate_count) &&
                       (st_q.intermediate_count <= st_q.final_count);

        // Wobble tick prescaler; it runs outside idle and is held at zero while the sequencer idles.
        if (st_q.tick_cnt >= 32'(TICK_CYCLES - 1)) begin
            st_d.tick_cnt = 32'h0000_0000;
            tick = 1'b1;
        end else begin
            st_d.tick_cnt = st_q.tick_cnt + 32'h0000_0001;
        end

        // Wobble phase sequencer.
        case (st_q.wob)
            WOB_IDLE: begin
                st_d.phase_cnt = 26'h0000000;
                // Hold the prescaler here, so that the first rise after idle
                // is a whole number of ticks and not a partial one.
                st_d.tick_cnt = 32'h0000_0000;
                if (st_q.swing_amplitude != 10'h000 && st_q.wobble_period != 16'h0000) begin
                    st_d.wob = WOB_RISE;
                end
            end
            WOB_RISE: begin
                if (tick) begin
                    st_d.phase_cnt = st_q.phase_cnt + 26'h0000001;
                    if (st_q.phase_cnt + 26'h0000001 >= rise_ticks) begin
                        st_d.phase_cnt = 26'h0000000;
                        st_d.wob = (fall_ticks == 26'h0000000) ? WOB_RISE : WOB_FALL;
                    end
                end
            end
            WOB_FALL: begin
                if (tick) begin
                    st_d.phase_cnt = st_q.phase_cnt + 26'h0000001;
                    if (st_q.phase_cnt + 26'h0000001 >= fall_ticks) begin
                        st_d.phase_cnt = 26'h0000000;
                        st_d.wob = WOB_RISE;
                    end
                end
            end
            default: begin
                st_d.wob = WOB_IDLE;
                st_d.phase_cnt = 26'h0000000;
            end
        endcase
        // No amplitude, no swing: the sequencer parks.
        if (st_q.swing_amplitude == 10'h000 || st_q.wobble_period == 16'h0000) begin
            st_d.wob = WOB_IDLE;
            st_d.phase_cnt = 26'h0000000;
        end

        // Interrupt events are the rising edges of the three flags.
        events[IRQ_LENGTH_BIT] = st_d.len_hit & ~st_q.len_hit;
        events[IRQ_FINAL_BIT] = st_d.fin_hit & ~st_q.fin_hit;
        events[IRQ_INTER_BIT] = st_d.int_hit & ~st_q.int_hit;
        // Write one to clear; a new event in the same cycle wins.
        if (bus_wr && (adr_i & 8'hFC) == OFS_IRQ_STATUS && sel_i[0]) begin
            st_d.status = st_q.status & ~dat_i[2:0];
        end
        st_d.status = st_d.status | events;
        st_d.irq = |(st_d.status & st_d.mask);

        // Read data, registered alongside ack; unmapped words read zero.
        case (adr_i & 8'hFC)
            OFS_WOBBLE_PERIOD: rd = {16'h0000, st_q.wobble_period};
            OFS_RISE_TIME_COEFF: rd = {22'h000000, st_q.rise_time_coeff};
            OFS_SWING_AMPLITUDE: rd = {22'h000000, st_q.swing_amplitude};
            OFS_TARGET_LENGTH: rd = {16'h0000, st_q.target_length};
            OFS_MEASURED_LENGTH: rd = {16'h0000, st_q.measured_length};
            OFS_PULSES_PER_METRE: rd = {16'h0000, st_q.pulses_per_metre};
            OFS_FINAL_COUNT: rd = {16'h0000, st_q.final_count};
            OFS_INTERMEDIATE_COUNT: rd = {16'h0000, st_q.intermediate_count};
            OFS_COUNT: rd = {16'h0000, st_q.count};
            OFS_TERM_FUNC_LO: rd = st_q.func_lo;
            OFS_TERM_FUNC_HI: rd = {16'h0000, st_q.func_hi};
            OFS_IRQ_STATUS: rd = {29'h00000000, st_q.status};
            OFS_IRQ_MASK: rd = {29'h00000000, st_q.mask};
            OFS_FLAGS: rd = {27'h0000000, st_q.wob == WOB_RISE, st_q.wob != WOB_IDLE,
                             st_q.int_hit, st_q.fin_hit, st_q.len_hit};
            default: rd = 32'h0000_0000;
        endcase
        st_d.rdat = bus_req ? rd : 32'h0000_0000;
    end

    // State register; reset gives documented defaults and clear flags.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= '0;
            st_q.wobble_period <= RST_WOBBLE_PERIOD;
            st_q.rise_time_coeff <= RST_RISE_TIME_COEFF;
            st_q.swing_amplitude <= RST_SWING_AMPLITUDE;
            st_q.target_length <= RST_TARGET_LENGTH;
            st_q.measured_length <= 16'h0000;
            st_q.pulses_per_metre <= RST_PULSES_PER_METRE;
            st_q.final_count <= RST_FINAL_COUNT;
            st_q.intermediate_count <= RST_INTERMEDIATE_COUNT;
            st_q.fin_hit <= 1'b0;
            st_q.int_hit <= 1'b0;
            st_q.wob <= WOB_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // All outputs come from the state register; swing_active_o and wobble_rising_o decode its wob field.
    assign dat_o = st_q.rdat;
    assign ack_o = st_q.ack;
    assign length_reached_o = st_q.len_hit;
    assign final_count_o = st_q.fin_hit;
    assign intermediate_count_o = st_q.int_hit;
    assign swing_active_o = st_q.wob != WOB_IDLE;
    assign wobble_rising_o = st_q.wob == WOB_RISE;
    assign irq_o = st_q.irq;

endmodule

`default_nettype wire

// *** verif/tlc_assertions.sv ***
// Concurrent checks on the ports of the traverse, length and count unit.
// Assumes one Wishbone request at a time and the small tick count of the bench.
`timescale 1ns/1ns
`default_nettype none
module tlc_checker #(
    parameter int TICK_CYCLES = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic length_reached_o,
    input wire logic final_count_o,
    input wire logic intermediate_count_o,
    input wire logic swing_active_o,
    input wire logic wobble_rising_o,
    input wire logic irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // A write request in flight; it may move the count or its limits.
    wire logic wr;
    assign wr = cyc_i && stb_i && we_i;
    chk_ack_one: assert property (ack_o |=> !ack_o)
        else $error("ack stood longer than one cycle");
    chk_ack_latency: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not answered in one cycle");
    chk_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without a request");
    chk_dat_idle: assert property (!ack_o |-> dat_o == 32'h0)
        else $error("read data not zero outside ack");
    // Reset must silence ack, irq and the length and count flags whatever state it interrupts.
    chk_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !ack_o &&
        !final_count_o && !intermediate_count_o && !length_reached_o && !irq_o)
        else $error("outputs not quiet after reset");
    // Counting stops at the limit, so only a register write may drop the flag.
    chk_final_hold: assert property (final_count_o && !wr && !$past(wr) &&
        !$past(wr, 2) |=> final_count_o)
        else $error("final count flag dropped without a write");
    // Rise lasts at least one tick; the figure matches the bench tick of 4.
    chk_rise_min: assert property ($rose(wobble_rising_o) |-> wobble_rising_o [*4])
        else $error("rise phase shorter than one tick");
    // With no amplitude there is no swing, so a swing can only start right
    // after a register write, and it always starts with a rise.
    chk_rise_swing: assert property ($rose(swing_active_o) |->
        wobble_rising_o && $past(wr))
        else $error("swing started without a write or not rising");
endmodule
bind tlc_top tlc_checker #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .dat_o(dat_o), .ack_o(ack_o),
    .length_reached_o(length_reached_o), .final_count_o(final_count_o),
    .intermediate_count_o(intermediate_count_o), .swing_active_o(swing_active_o),
    .wobble_rising_o(wobble_rising_o), .irq_o(irq_o));
`default_nettype wire

// *** verif/tlc_term_model.sv ***
// Pulse source standing in for the multi-function input terminals.
// Assumes the bench calls its tasks; levels change just after rising edges.
`timescale 1ns/1ns
`default_nettype none
module tlc_term_model (
    input wire logic clk_i,
    output logic [5:0] term_o
);
    initial term_o = 6'h00; // All terminals idle low.
    // Four cycles high and at least four low, above the two that the input filter needs.
    task automatic pulse(input int t, input int n);
        repeat (n) begin
            @(posedge clk_i) term_o[t] <= 1'b1;
            repeat (4) @(posedge clk_i);
            term_o[t] <= 1'b0;
            repeat (4) @(posedge clk_i);
        end
    endtask
    // Holds one terminal at a steady level, as a clear switch would.
    task automatic level(input int t, input logic v);
        @(posedge clk_i) term_o[t] <= v;
    endtask
endmodule
`default_nettype wire

// *** verif/tb.sv ***
// Self-checking bench for the traverse, length and count unit.
// Assumes the terminal model and the bound checker are compiled alongside.
`timescale 1ns/1ns
`default_nettype none
module tb;
    import tlc_pkg::*;
    localparam int TICK = 4; // Short tick so a wobble cycle fits the run.
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rd;
    wire [31:0] dat_o;
    wire ack_o, len_o, fin_o, int_o, swg_o, ris_o, irq_o;
    wire [5:0] term_w;
    int err_count = 0;
    int tests_run = 0;
    always #2 clk_i = ~clk_i;
    tlc_top #(.TICK_CYCLES(TICK)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dat_o),
        .ack_o(ack_o), .term_i(term_w), .length_reached_o(len_o), .final_count_o(fin_o),
        .intermediate_count_o(int_o), .swing_active_o(swg_o), .wobble_rising_o(ris_o),
        .irq_o(irq_o));
    tlc_term_model term_u (.clk_i(clk_i), .term_o(term_w));
    // Metres expected from a pulse count; each pulse is ten tenths.
    function automatic int metres(input int p, input int ppm);
        return p * 10 / ppm;
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One classic cycle; the request stands until ack is sampled high.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hF;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 50) err_count++;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        check(rd, e);
    endtask
    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Watchdog: the longest part is one slow wobble cycle of about 4000 clocks.
    initial begin
        repeat (40000) @(posedge clk_i);
        err_count++;
        finish_test();
    end
    initial begin
        int c, k, f, p, n;
        logic [31:0] seed;
        seed = $urandom(41);
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk(OFS_RISE_TIME_COEFF, 32'h1F4);
        rdchk(OFS_MEASURED_LENGTH, 32'h0);
        rdchk(OFS_PULSES_PER_METRE, 32'h3E8);
        rdchk(OFS_TARGET_LENGTH, 32'h3E8);
        rdchk(OFS_FINAL_COUNT, 32'h3E8);
        rdchk(OFS_FLAGS, 32'h0);
        rdchk(8'h3C, 32'h0);
        // Terminal 3 gets an unrelated code; terminal 5 is the fast counter input.
        wb(1'b1, OFS_TERM_FUNC_LO, {8'h07, FUNC_LENGTH_CLR, FUNC_LENGTH_IN, FUNC_COUNT_IN});
        wb(1'b1, OFS_TERM_FUNC_HI, {16'h0, FUNC_COUNT_IN, 8'h00});
        f = 3 + $urandom % 6;
        k = 1 + $urandom % (f - 1);
        wb(1'b1, OFS_FINAL_COUNT, f);
        wb(1'b1, OFS_INTERMEDIATE_COUNT, k);
        term_u.pulse(3, 2);
        rdchk(OFS_COUNT, 32'h0);
        for (n = 0; n < k; n++) term_u.pulse(($urandom % 2) ? 5 : 0, 1);
        rdchk(OFS_COUNT, k);
        check({fin_o, int_o}, 2'b01);
        term_u.pulse(0, f - k + 2);
        rdchk(OFS_COUNT, f);
        check({fin_o, int_o, irq_o}, 3'b110);
        wb(1'b1, OFS_IRQ_MASK, 32'h2);
        @(posedge clk_i);
        check(irq_o, 1'b1);
        wb(1'b1, OFS_IRQ_STATUS, 32'h2);
        @(posedge clk_i);
        check(irq_o, 1'b0);
        wb(1'b1, OFS_CTRL, 32'h1);
        rdchk(OFS_COUNT, 32'h0);
        // Two pulses a metre, so an odd count leaves half a metre unseen.
        wb(1'b1, OFS_PULSES_PER_METRE, 32'd20);
        wb(1'b1, OFS_TARGET_LENGTH, 32'd2);
        p = 4 + $urandom % 6;
        term_u.pulse(1, p);
        rdchk(OFS_MEASURED_LENGTH, metres(p, 20));
        check(len_o, metres(p, 20) > 2);
        term_u.level(2, 1'b1);
        term_u.pulse(1, 2);
        rdchk(OFS_MEASURED_LENGTH, 32'h0);
        check(len_o, 1'b0);
        term_u.level(2, 1'b0);
        wb(1'b1, OFS_RISE_TIME_COEFF, 32'h0);
        rdchk(OFS_RISE_TIME_COEFF, 32'h1);
        c = 2 + $urandom % 8;
        wb(1'b1, OFS_RISE_TIME_COEFF, c);
        wb(1'b1, OFS_WOBBLE_PERIOD, 32'h1);
        n = 0;
        repeat (50) @(posedge clk_i) n += (swg_o !== 1'b0);
        check(n, 0);
        wb(1'b1, OFS_SWING_AMPLITUDE, 32'h5);
        // Skip any rise already under way so a whole phase is timed.
        while (ris_o === 1'b1) @(posedge clk_i);
        while (ris_o !== 1'b1) @(posedge clk_i);
        n = 0;
        while (ris_o === 1'b1) @(posedge clk_i) n++;
        check(n, c * TICK);
        n = 0;
        while (ris_o !== 1'b1) @(posedge clk_i) n++;
        check(n, (1000 - c) * TICK);
        // Reset in mid-swing must bring every flag back to rest.
        @(posedge clk_i) rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk(OFS_FLAGS, 32'h0);
        rdchk(OFS_MEASURED_LENGTH, 32'h0);
        finish_test();
    end
endmodule
`default_nettype wire
